// ---- core/boot_loader_pkg.sv ----
// Shared constants, state type and address decode for the boot loader
package boot_loader_pkg;

    // Clock and memory geometry
    localparam int CLK_MHZ          = 40;
    localparam int CLK_NS           = 25;
    localparam int BOOT_ROM_BYTES   = 131072;
    localparam int HOST_FLASH_BYTES = 2097152;
    localparam int REC_FLASH_BYTES  = 1048576;
    localparam int ACQ_FLASH_BYTES  = 262144;
    localparam int CARD_BANK_BYTES  = 524288;
    localparam int BANK_OFS_W       = 19;
    localparam int CARD_ADDR_W      = 22;
    localparam int BANK_W           = CARD_ADDR_W - BANK_OFS_W;
    localparam int FLASH_ADDR_W     = 21;
    localparam int DATA_W           = 16;

    // Card layout: signature in attribute space, images in common space
    localparam logic [21:0] SIG_ADDR      = 22'h000000;
    localparam logic [21:0] HOST_IMG_ADDR = 22'h000000;
    localparam logic [21:0] REC_IMG_ADDR  = 22'h200000;
    localparam logic [21:0] ACQ_IMG_ADDR  = 22'h300000;
    // Card signature word; value is arbitrary
    localparam logic [15:0] CARD_SIGNATURE = 16'h5a3c;

    // Backup data validity
    localparam logic [15:0] OFF_LIMIT_MIN = 16'h001e;

    // Key poll interval and serial bit time
    localparam int KEY_POLL_US    = 10000;
    localparam int KEY_POLL_CYC   = KEY_POLL_US * CLK_MHZ;
    localparam int SER_BIT_NS     = 1000;
    localparam int SER_BIT_CYC    = SER_BIT_NS / CLK_NS;
    localparam int SER_FRAME_BITS = 18;

    typedef enum {
        ST_CHECK, ST_SIG, ST_COPY_RD, ST_COPY_WR,
        ST_SER_RD, ST_SER_TX, ST_RUN
    } loader_state_e;

    // Bank number of a linear card byte address
    function automatic logic [BANK_W-1:0] card_bank(
        input logic [CARD_ADDR_W-1:0] addr);
        card_bank = addr[CARD_ADDR_W-1:BANK_OFS_W];
    endfunction : card_bank

endpackage : boot_loader_pkg

// ---- core/card_map_if.sv ----
// Linear card address in, bank and window offset out
`timescale 1ns/1ps
interface card_map_if;
    import boot_loader_pkg::*;
    logic [CARD_ADDR_W-1:0] lin_addr;
    logic                   attr;
    logic [BANK_W-1:0]      bank;
    logic [BANK_OFS_W-1:0]  offset;
    logic                   attr_sel;
    logic                   clk;
    modport requester (output lin_addr, output attr, output clk,
                       input bank, input offset, input attr_sel);
    modport mapper (input lin_addr, input attr, input clk,
                    output bank, output offset, output attr_sel);
endinterface : card_map_if

// ---- core/card_bank_mapper.sv ----
// Splits a card address into a 512 KB bank and an offset in the bank
`timescale 1ns/1ps
module card_bank_mapper
    import boot_loader_pkg::*;
(
    card_map_if.mapper m
);
    assign m.bank   = card_bank(m.lin_addr);
    assign m.offset = m.lin_addr[BANK_OFS_W-1:0];
    assign m.attr_sel = m.attr;

    // Bank must be the address over the bank size, so a wrong
    // offset width shows up here
    // bank window size
    bank_window_a: assert property (@(posedge m.clk)
        m.bank == BANK_W'(m.lin_addr / CARD_BANK_BYTES))
        else $error("bank window size wrong");
endmodule : card_bank_mapper

// ---- core/boot_program_loader.sv ----
// Boot loader: card check, flash copy, serial reflash, RAM share, keys
// What this block does
// - After reset the processor fetches from the boot memory first.
// - Boot code tests for a card in the slot and checks its signature.
// - A correct card has its images copied into every system flash.
// - Targets are the main flash and the recorder module's flash.
// - With no card, execution passes to the main system memory.
// - Card memory is mapped through banks of 512 KB each.
// - The host chooses attribute or common card memory per access.
// - After a long off period with a drained capacitor, data is reset.
// - Acquisition processor results reach the host via shared RAM.
// - An upgrade rewrites the acquisition flash over a serial link.
// - Hard keys are polled at a fixed interval and acted upon.
`timescale 1ns/1ps
module boot_program_loader
    import boot_loader_pkg::*;
#(
    parameter int HOST_IMG_BYTES = HOST_FLASH_BYTES,
    parameter int REC_IMG_BYTES  = REC_FLASH_BYTES,
    parameter int ACQ_IMG_BYTES  = ACQ_FLASH_BYTES,
    parameter int POLL_CYC       = KEY_POLL_CYC,
    parameter int KEY_W          = 8,
    parameter int RAM_AW         = 19
) (
    input  wire logic                    i_mclk,
    input  wire logic                    i_rstn,
    input  wire logic                    i_card_present,
    input  wire logic [DATA_W-1:0]       i_card_rdata,
    input  wire logic                    i_card_ack,
    output logic                         o_card_rd,
    output logic [BANK_W-1:0]            o_card_bank,
    output logic [BANK_OFS_W-1:0]        o_card_offset,
    output logic                         o_card_attr,
    input  wire logic                    i_host_card_rd,
    input  wire logic [CARD_ADDR_W-1:0]  i_host_card_addr,
    input  wire logic                    i_host_card_attr,
    output logic                         o_host_card_ack,
    output logic [DATA_W-1:0]            o_host_card_rdata,
    output logic                         o_flash_wr,
    output logic                         o_flash_sel,
    output logic [FLASH_ADDR_W-1:0]      o_flash_addr,
    output logic [DATA_W-1:0]            o_flash_wdata,
    input  wire logic                    i_flash_ack,
    output logic                         o_acq_prog_en,
    output logic                         o_acq_txd,
    input  wire logic                    i_acq_ram_req,
    input  wire logic [RAM_AW-1:0]       i_acq_ram_addr,
    input  wire logic [DATA_W-1:0]       i_acq_ram_wdata,
    output logic                         o_acq_ram_gnt,
    input  wire logic                    i_host_ram_req,
    input  wire logic                    i_host_ram_we,
    input  wire logic [RAM_AW-1:0]       i_host_ram_addr,
    input  wire logic [DATA_W-1:0]       i_host_ram_wdata,
    output logic                         o_host_ram_gnt,
    output logic [DATA_W-1:0]            o_host_ram_rdata,
    output logic                         o_ram_en,
    output logic                         o_ram_we,
    output logic [RAM_AW-1:0]            o_ram_addr,
    output logic [DATA_W-1:0]            o_ram_wdata,
    input  wire logic [DATA_W-1:0]       i_ram_rdata,
    input  wire logic                    i_cap_low,
    input  wire logic [15:0]             i_off_minutes,
    output logic                         o_backup_reinit,
    input  wire logic [KEY_W-1:0]        i_keys,
    output logic [KEY_W-1:0]             o_key_state,
    output logic                         o_key_event,
    output logic                         o_boot_fetch,
    output logic                         o_run_system,
    output logic                         o_upgrade_done
);

    loader_state_e             state;
    logic                      phase;
    logic [CARD_ADDR_W:0]      cnt;
    logic [DATA_W-1:0]         data;
    logic [SER_FRAME_BITS-1:0] shreg;
    logic [5:0]                bit_cnt;
    logic [15:0]               baud_cnt;
    logic                      bk_checked;
    logic                      host_rd_pend;
    logic [31:0]               poll_cnt;
    logic [CARD_ADDR_W-1:0]    img_base;
    logic [CARD_ADDR_W:0]      img_len;
    logic                      last_word;
    logic                      sig_ok;

    card_map_if cm ();

    ////////////////////////////////////////////////////////////////////
    // Card address mapping

    card_bank_mapper u_map (
        .m (cm.mapper)
    );

    // The mapper has no clock of its own; its checks use this one
    assign cm.clk = i_mclk;

    // Image base and length follow the copy phase
    always_comb begin
        if (state == ST_SER_RD || state == ST_SER_TX) begin
            img_base = ACQ_IMG_ADDR;
            img_len  = (CARD_ADDR_W+1)'(ACQ_IMG_BYTES);
        end else if (phase) begin
            img_base = REC_IMG_ADDR;
            img_len  = (CARD_ADDR_W+1)'(REC_IMG_BYTES);
        end else begin
            img_base = HOST_IMG_ADDR;
            img_len  = (CARD_ADDR_W+1)'(HOST_IMG_BYTES);
        end
    end

    assign last_word = (cnt + (CARD_ADDR_W+1)'(2)) >= img_len;
    assign sig_ok    = (i_card_rdata == CARD_SIGNATURE);

    // Loader owns the card until the system runs, then the host does
    // attribute or common
    always_comb begin
        cm.attr     = 1'b0;
        cm.lin_addr = img_base + cnt[CARD_ADDR_W-1:0];
        o_card_rd   = 1'b0;
        case (state)
            ST_SIG: begin
                cm.attr     = 1'b1;
                cm.lin_addr = SIG_ADDR;
                o_card_rd   = 1'b1;
            end
            ST_COPY_RD, ST_SER_RD: o_card_rd = 1'b1;
            ST_RUN: begin
                cm.attr     = i_host_card_attr;
                cm.lin_addr = i_host_card_addr;
                o_card_rd   = i_host_card_rd;
            end
            default: o_card_rd = 1'b0;
        endcase
    end

    assign o_card_bank     = cm.bank;
    assign o_card_offset   = cm.offset;
    assign o_card_attr     = cm.attr_sel;
    assign o_host_card_ack = (state == ST_RUN) && i_card_ack;

    ////////////////////////////////////////////////////////////////////
    // Boot sequence

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            state <= ST_CHECK;
            phase <= 1'b0;
            cnt   <= '0;
        end else begin
            case (state)
                ST_CHECK: begin
                    state <= i_card_present ? ST_SIG : ST_RUN;
                end
                ST_SIG: if (i_card_ack) begin
                    state <= sig_ok ? ST_COPY_RD : ST_RUN;
                    cnt   <= '0;
                    phase <= 1'b0;
                end
                ST_COPY_RD: if (i_card_ack) begin
                    state <= ST_COPY_WR;
                end
                ST_COPY_WR: if (i_flash_ack) begin
                    if (!last_word) begin
                        cnt   <= cnt + (CARD_ADDR_W+1)'(2);
                        state <= ST_COPY_RD;
                    end else if (!phase) begin
                        phase <= 1'b1;
                        cnt   <= '0;
                        state <= ST_COPY_RD;
                    end else begin
                        cnt   <= '0;
                        state <= ST_SER_RD;
                    end
                end
                ST_SER_RD: if (i_card_ack) begin
                    state <= ST_SER_TX;
                end
                ST_SER_TX: if (bit_cnt == 6'(SER_FRAME_BITS) &&
                               baud_cnt == 16'(SER_BIT_CYC - 1)) begin
                    cnt   <= cnt + (CARD_ADDR_W+1)'(2);
                    state <= last_word ? ST_RUN : ST_SER_RD;
                end
                ST_RUN: state <= ST_RUN;
                default: state <= ST_CHECK;
            endcase
        end
    end

    // Card word latches: data for the copy, o_host_card_rdata for host reads; reflash loads shreg directly
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            data              <= '0;
            o_host_card_rdata <= '0;
        end else if (i_card_ack) begin
            if (state == ST_RUN)
                o_host_card_rdata <= i_card_rdata;
            else
                data <= i_card_rdata;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_boot_fetch   <= 1'b1;
            o_run_system   <= 1'b0;
            o_upgrade_done <= 1'b0;
        end else begin
            o_boot_fetch <= (state != ST_RUN) &&
                            !(state == ST_CHECK && !i_card_present) &&
                            !(state == ST_SIG && i_card_ack && !sig_ok);
            o_run_system <= !o_boot_fetch || state == ST_RUN ||
                            (state == ST_CHECK && !i_card_present) ||
                            (state == ST_SIG && i_card_ack && !sig_ok);
            if (state == ST_SER_TX && last_word &&
                bit_cnt == 6'(SER_FRAME_BITS) &&
                baud_cnt == 16'(SER_BIT_CYC - 1))
                o_upgrade_done <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Flash write port

    // Data comes from the latch so it is stable for the whole write
    assign o_flash_wr    = (state == ST_COPY_WR);
    assign o_flash_sel   = phase;
    assign o_flash_addr  = cnt[FLASH_ADDR_W-1:0];
    assign o_flash_wdata = data;

    ////////////////////////////////////////////////////////////////////
    // Serial reflash of the acquisition processor

    // serial frame: start, 16 data bits lsb first, stop
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            shreg    <= '1;
            bit_cnt  <= '0;
            baud_cnt <= '0;
        end else if (state == ST_SER_RD) begin
            shreg    <= {1'b1, i_card_rdata, 1'b0};
            bit_cnt  <= '0;
            baud_cnt <= '0;
        end else if (state == ST_SER_TX) begin
            if (baud_cnt == 16'(SER_BIT_CYC - 1)) begin
                baud_cnt <= '0;
                bit_cnt  <= bit_cnt + 6'(1);
                shreg    <= {1'b1, shreg[SER_FRAME_BITS-1:1]};
            end else begin
                baud_cnt <= baud_cnt + 16'(1);
            end
        end
    end

    // Line idles high; program enable covers the whole reflash
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_acq_txd     <= 1'b1;
            o_acq_prog_en <= 1'b0;
        end else begin
            o_acq_txd     <= (state == ST_SER_TX &&
                              bit_cnt < 6'(SER_FRAME_BITS)) ? shreg[0]
                                                            : 1'b1;
            o_acq_prog_en <= (state == ST_SER_RD || state == ST_SER_TX);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Shared RAM arbiter

    // acquisition deposits
    // The acquisition side wins: its results must not be dropped,
    // the host simply retries the next cycle
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_ram_en       <= 1'b0;
            o_ram_we       <= 1'b0;
            o_ram_addr     <= '0;
            o_ram_wdata    <= '0;
            o_acq_ram_gnt  <= 1'b0;
            o_host_ram_gnt <= 1'b0;
            host_rd_pend   <= 1'b0;
        end else begin
            o_acq_ram_gnt  <= i_acq_ram_req;
            o_host_ram_gnt <= i_host_ram_req && !i_acq_ram_req;
            o_ram_en       <= i_acq_ram_req || i_host_ram_req;
            host_rd_pend   <= i_host_ram_req && !i_acq_ram_req &&
                              !i_host_ram_we;
            if (i_acq_ram_req) begin
                o_ram_we    <= 1'b1;
                o_ram_addr  <= i_acq_ram_addr;
                o_ram_wdata <= i_acq_ram_wdata;
            end else begin
                o_ram_we    <= i_host_ram_req && i_host_ram_we;
                o_ram_addr  <= i_host_ram_addr;
                o_ram_wdata <= i_host_ram_wdata;
            end
        end
    end

    // Host read data arrives one cycle after the RAM enable
    always_ff @(posedge i_mclk) begin
        if (!i_rstn)
            o_host_ram_rdata <= '0;
        else if (host_rd_pend)
            o_host_ram_rdata <= i_ram_rdata;
    end

    ////////////////////////////////////////////////////////////////////
    // Backup data check and key polling

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            bk_checked      <= 1'b0;
            o_backup_reinit <= 1'b0;
        end else begin
            bk_checked      <= 1'b1;
            o_backup_reinit <= !bk_checked && i_cap_low &&
                               (i_off_minutes > OFF_LIMIT_MIN);
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            poll_cnt    <= '0;
            o_key_state <= '0;
            o_key_event <= 1'b0;
        end else if (poll_cnt == 32'(POLL_CYC - 1)) begin
            poll_cnt    <= '0;
            o_key_state <= i_keys;
            o_key_event <= (i_keys != o_key_state);
        end else begin
            poll_cnt    <= poll_cnt + 32'(1);
            o_key_event <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);

    boot_first_a: assert property ($rose(i_rstn) |-> o_boot_fetch &&
        !o_run_system) else $error("boot memory not first");
    card_check_a: assert property (state == ST_CHECK && i_card_present
        |=> state == ST_SIG && o_card_rd && o_card_attr)
        else $error("card not checked");
    copy_start_a: assert property (state == ST_SIG && i_card_ack &&
        sig_ok |=> state == ST_COPY_RD && !phase && cnt == '0)
        else $error("copy did not start");
    flash_target_a: assert property (state == ST_COPY_WR &&
        i_flash_ack && last_word && !phase |=> phase &&
        state == ST_COPY_RD) else $error("recorder flash skipped");
    no_card_a: assert property (state == ST_CHECK && !i_card_present
        |=> ##1 o_run_system && !o_boot_fetch)
        else $error("no card did not run system");
    bank_map_a: assert property (state == ST_COPY_RD |->
        {o_card_bank, o_card_offset} ==
        (phase ? REC_IMG_ADDR : HOST_IMG_ADDR) + cnt[21:0])
        else $error("card bank mapping wrong");
    host_space_a: assert property (state == ST_RUN && i_host_card_rd
        |-> o_card_attr == i_host_card_attr && o_card_rd)
        else $error("host space select lost");
    backup_init_a: assert property (!bk_checked && i_cap_low &&
        i_off_minutes > OFF_LIMIT_MIN |=> o_backup_reinit ##1
        !o_backup_reinit) else $error("backup reinit wrong");
    acq_ram_a: assert property (i_acq_ram_req |=> o_ram_we && o_ram_en
        && o_acq_ram_gnt && !o_host_ram_gnt &&
        o_ram_addr == $past(i_acq_ram_addr))
        else $error("acquisition write lost");
    ser_bit_a: assert property ($fell(o_acq_txd) |-> !o_acq_txd [*8])
        else $error("serial bit too short");
    key_poll_a: assert property (poll_cnt == 32'(POLL_CYC - 1) |=>
        o_key_state == $past(i_keys) && poll_cnt == '0)
        else $error("key poll missed");
    bad_card_a: assert property (state == ST_SIG && i_card_ack &&
        !sig_ok |=> state == ST_RUN ##1 o_run_system && !o_upgrade_done)
        else $error("bad card not treated as absent");

    upgrade_c: cover property ($rose(o_upgrade_done));
    no_card_c: cover property (state == ST_CHECK && !i_card_present);
    key_event_c: cover property (o_key_event);
    arb_clash_c: cover property (i_acq_ram_req && i_host_ram_req);

endmodule : boot_program_loader

// ---- sim/card_flash_model.sv ----
// Partner model: program card and system flash, answering after a delay
`timescale 1ns/1ps
module card_flash_model
    import boot_loader_pkg::*;
(
    input  wire logic                  i_mclk,
    input  wire logic                  i_rstn,
    input  wire logic                  i_rd,
    input  wire logic [BANK_W-1:0]     i_bank,
    input  wire logic [BANK_OFS_W-1:0] i_offset,
    input  wire logic                  i_attr,
    input  wire logic                  i_wr,
    input  wire logic                  i_bad_sig,
    input  wire logic [1:0]            i_delay,
    output logic                       o_ack,
    output logic [DATA_W-1:0]          o_rdata,
    output logic                       o_wr_ack
);
    logic [1:0] rd_wait;
    logic [1:0] wr_wait;

    // Word held at a card byte address; differs between images
    function automatic logic [15:0] pat(input logic [21:0] a);
        pat = a[15:0] ^ {a[21:16], 10'h2b5};
    endfunction : pat

    ////////////////////////////////////////////////////////////////
    // Card read: data only in the ack cycle, scrambled otherwise so
    // that a stale word never passes for a fresh one
    always_ff @(posedge i_mclk) begin
        o_ack   <= 1'b0;
        o_rdata <= ~o_rdata;
        if (!i_rstn) begin
            rd_wait <= 2'h0;
            o_rdata <= 16'h0000;
        end else if (i_rd && !o_ack) begin
            rd_wait <= rd_wait + 2'h1;
            if (rd_wait >= i_delay) begin
                rd_wait <= 2'h0;
                o_ack   <= 1'b1;
                o_rdata <= i_attr ? CARD_SIGNATURE ^ {15'h0000, i_bad_sig}
                                  : pat({i_bank, i_offset});
            end
        end
    end

    // Flash write completes after the same delay as a card read
    always_ff @(posedge i_mclk) begin
        o_wr_ack <= 1'b0;
        if (!i_rstn) begin
            wr_wait <= 2'h0;
        end else if (i_wr && !o_wr_ack) begin
            wr_wait <= wr_wait + 2'h1;
            if (wr_wait >= i_delay) begin
                wr_wait  <= 2'h0;
                o_wr_ack <= 1'b1;
            end
        end
    end
endmodule : card_flash_model

// ---- sim/boot_program_loader_test.sv ----
// Self-checking bench for the boot loader with card and flash model
`timescale 1ns/1ps
module boot_program_loader_test
    import boot_loader_pkg::*;
;
    logic        i_mclk = 1'b0, i_rstn = 1'b0, i_card_present = 1'b0;
    logic        i_host_card_rd = 1'b0, i_host_card_attr = 1'b0;
    logic        i_acq_ram_req = 1'b0, i_host_ram_req = 1'b0;
    logic        i_host_ram_we = 1'b0, i_cap_low = 1'b0, bad_sig = 1'b0;
    logic [1:0]  delay = 2'h0;
    logic [15:0] i_acq_ram_wdata = 16'h0000, i_host_ram_wdata = 16'h0000;
    logic [15:0] i_ram_rdata = 16'h0000, i_off_minutes = 16'h0000;
    logic [21:0] i_host_card_addr = 22'h000000;
    logic [18:0] i_acq_ram_addr = 19'h00000, i_host_ram_addr = 19'h00000;
    logic [7:0]  i_keys = 8'h00;
    logic        i_card_ack, i_flash_ack, o_card_rd, o_card_attr;
    logic        o_host_card_ack, o_flash_wr, o_flash_sel, o_acq_prog_en;
    logic        o_acq_txd, o_acq_ram_gnt, o_host_ram_gnt, o_ram_en;
    logic        o_ram_we, o_backup_reinit, o_key_event, o_boot_fetch;
    logic        o_run_system, o_upgrade_done;
    logic [15:0] i_card_rdata, o_host_card_rdata, o_flash_wdata;
    logic [15:0] o_host_ram_rdata, o_ram_wdata, word;
    logic [18:0] o_card_offset, o_ram_addr;
    logic [20:0] o_flash_addr;
    logic [7:0]  o_key_state;
    logic [2:0]  o_card_bank;
    logic [38:0] notes[$];
    int          err_count, checks, n, pulses;

    always #(CLK_NS / 2.0) i_mclk = ~i_mclk;

    // Short images and poll time keep the run brief
    boot_program_loader #(.HOST_IMG_BYTES(8), .REC_IMG_BYTES(4),
        .ACQ_IMG_BYTES(4), .POLL_CYC(16)) i_dut (.*);
    card_flash_model i_card (.i_mclk(i_mclk), .i_rstn(i_rstn),
        .i_rd(o_card_rd), .i_bank(o_card_bank), .i_offset(o_card_offset),
        .i_attr(o_card_attr), .i_wr(o_flash_wr), .i_bad_sig(bad_sig),
        .i_delay(delay), .o_ack(i_card_ack), .o_rdata(i_card_rdata),
        .o_wr_ack(i_flash_ack));

    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [38:0] seen, input logic [38:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic close_out();
        if (err_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    // Reset with given slot and backup state, then wait for the system
    task automatic boot(input logic pres, bad, cap,
                        input logic [15:0] off, input int lim);
        @(posedge i_mclk);
        i_rstn         <= 1'b0;
        i_card_present <= pres;
        bad_sig        <= bad;
        i_cap_low      <= cap;
        i_off_minutes  <= off;
        delay          <= 2'($urandom_range(0, 3));
        repeat (5) @(posedge i_mclk);
        #1;
        chk(o_boot_fetch, 1'b1);
        chk(o_run_system, 1'b0);
        @(posedge i_mclk);
        i_rstn <= 1'b1;
        pulses = 0;
        for (n = 0; n < lim && o_run_system !== 1'b1; n++) begin
            @(posedge i_mclk);
            #1;
            pulses += int'(o_backup_reinit);
        end
        chk(pulses, cap && off > 16'h001e);
        chk(o_run_system, 1'b1);
        chk(o_boot_fetch, 1'b0);
    endtask : boot

    // Host card access held until the card answers
    task automatic host_rd(input logic [21:0] a, input logic at);
        @(posedge i_mclk);
        i_host_card_rd   <= 1'b1;
        i_host_card_addr <= a;
        i_host_card_attr <= at;
        for (n = 0; n < 20; n++) begin
            @(posedge i_mclk);
            if (o_host_card_ack === 1'b1) break;
        end
        chk({o_host_card_ack, o_card_rd}, 2'h3);
        chk(o_card_bank, a[21:19]);
        chk(o_card_offset, a[18:0]);
        chk(o_card_attr, at);
        i_host_card_rd <= 1'b0;
        #1;
        chk(o_host_card_rdata, at ? CARD_SIGNATURE : i_card.pat(a));
    endtask : host_rd

    ////////////////////////////////////////////////////////////////
    // flash writes matched to oldest note
    always @(posedge i_mclk) begin
        if (o_flash_wr === 1'b1 && i_flash_ack === 1'b1) begin
            if (notes.size() == 0) chk(1'b1, 1'b0);
            else chk({1'b0, o_flash_sel, o_flash_addr, o_flash_wdata},
                     notes.pop_front());
        end
    end

    // serial frame decode, sampled mid-bit, LSB first
    initial forever begin
        @(negedge o_acq_txd);
        if (o_acq_prog_en === 1'b1) begin
            repeat (SER_BIT_CYC / 2) @(posedge i_mclk);
            chk(o_acq_txd, 1'b0);
            for (int b = 0; b < 16; b++) begin
                repeat (SER_BIT_CYC) @(posedge i_mclk);
                word[b] = o_acq_txd;
            end
            repeat (SER_BIT_CYC) @(posedge i_mclk);
            chk(o_acq_txd, 1'b1);
            chk(o_acq_prog_en, 1'b1);
            chk({2'h2, 21'h0, word}, notes.pop_front());
        end
    end

    // Hang guard, well above the longest boot
    initial begin
        repeat (20000) @(posedge i_mclk);
        err_count++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(65));
        boot(1'b0, 1'b0, 1'b1, 16'h001f, 60);
        // one key change gives one event
        @(posedge i_mclk);
        i_keys <= 8'($urandom_range(1, 255));
        pulses = 0;
        repeat (36) begin
            @(posedge i_mclk);
            #1;
            pulses += int'(o_key_event);
        end
        chk(o_key_state, i_keys);
        chk(pulses, 1);
        // acquisition write wins, host retries alone
        @(posedge i_mclk);
        i_acq_ram_req   <= 1'b1;
        i_acq_ram_addr  <= 19'($urandom);
        i_acq_ram_wdata <= 16'($urandom);
        i_host_ram_req  <= 1'b1;
        i_host_ram_addr <= 19'($urandom);
        i_ram_rdata     <= 16'($urandom);
        @(posedge i_mclk);
        i_acq_ram_req <= 1'b0;
        #1;
        chk({o_acq_ram_gnt, o_host_ram_gnt, o_ram_en, o_ram_we}, 4'hb);
        chk({o_ram_addr, o_ram_wdata},
            {i_acq_ram_addr, i_acq_ram_wdata});
        @(posedge i_mclk);
        i_host_ram_req <= 1'b0;
        #1;
        chk({o_host_ram_gnt, o_ram_en, o_ram_we, o_ram_addr},
            {3'h6, i_host_ram_addr});
        repeat (2) @(posedge i_mclk);
        #1;
        chk(o_host_ram_rdata, i_ram_rdata);
        // Host write alone is granted and reaches the RAM port
        @(posedge i_mclk);
        i_host_ram_req   <= 1'b1;
        i_host_ram_we    <= 1'b1;
        i_host_ram_wdata <= 16'($urandom);
        @(posedge i_mclk);
        i_host_ram_req <= 1'b0;
        #1;
        chk({o_host_ram_gnt, o_ram_we, o_ram_wdata},
            {2'h3, i_host_ram_wdata});
        for (int k = 0; k < 4; k++) host_rd(22'($urandom), k[0]);
        boot(1'b1, 1'b1, 1'b1, 16'h001e, 60);
        // Expected image words for main flash, recorder and serial link
        for (int k = 0; k < 4; k++)
            notes.push_back({2'h0, 21'(2 * k), i_card.pat(22'(2 * k))});
        for (int k = 0; k < 2; k++)
            notes.push_back({2'h1, 21'(2 * k),
                i_card.pat(REC_IMG_ADDR + 22'(2 * k))});
        for (int k = 0; k < 2; k++)
            notes.push_back({2'h2, 21'h0,
                i_card.pat(ACQ_IMG_ADDR + 22'(2 * k))});
        boot(1'b1, 1'b0, 1'b0, 16'hffff, 6000);
        chk(o_upgrade_done, 1'b1);
        chk(o_acq_prog_en, 1'b0);
        chk(notes.size(), 0);
        close_out();
    end
endmodule : boot_program_loader_test
